// ===== design/wwrt_cnt_if.sv
// Link between the watchdog control logic and its tick counter
`timescale 1ns/1ps
`default_nettype none

interface wwrt_cnt_if #(
	parameter int unsigned CW = 32
);
	logic          clear;
	logic          run;
	logic [CW-1:0] limit;
	logic [CW-1:0] count;
	logic          hit;

	// ==========================================================
	// Control side and counter side
	// ==========================================================
	modport ctl (output clear, output run, output limit, input count, input hit);
	modport cnt (input clear, input run, input limit, output count, output hit);
endinterface

`default_nettype wire

// ===== design/wwrt_counter.sv
// Tick counter of the warm reset watchdog
`timescale 1ns/1ps
`default_nettype none

module wwrt_counter #(
	parameter int unsigned CW = 32
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	wwrt_cnt_if.cnt   bus
);
	import wwrt_pkg::*;

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;

	// ==========================================================
	// Count one step per clock while running
	// ==========================================================
	always_comb begin
		next_count = count;
		if (bus.clear) begin
			next_count = '0;
		end else if (bus.run) begin
			next_count = count + CW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Greater-or-equal so a limit lowered below the count still fires
	assign bus.count = count;
	assign bus.hit   = bus.run && (count >= bus.limit);

	// ==========================================================
	// Checks on the counter
	// ==========================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_count_steps_one: assert property (
		bus.run && !bus.clear |=> count == $past(count) + CW'(1))
		else $error("Counter did not advance by one");
	a_hit_at_limit: assert property (bus.run && count == bus.limit |-> bus.hit)
		else $error("Counter reached limit without hit");
	a_clear_zeroes: assert property (bus.clear |=> count == '0)
		else $error("Counter not zero after clear");
endmodule

`default_nettype wire

// ===== design/wwrt_pkg.sv
// Shared constants and types for the warm reset watchdog timer
`default_nettype none

package wwrt_pkg;

	// ==========================================================
	// Clock and default timeout
	// ==========================================================
	localparam int unsigned CLK_FREQ_KHZ  = 250000;   // core_clk rate, 4 ns period
	localparam int unsigned TMO_DEF_MS    = 2;        // Default timeout, milliseconds
	localparam int unsigned TMO_DEF_CYC   = TMO_DEF_MS * CLK_FREQ_KHZ;

	// ==========================================================
	// Counter and reset pulse shaping
	// ==========================================================
	localparam int unsigned CNT_W_DEF     = 32;       // Default counter width
	localparam int unsigned RST_HOLD_CYC  = 8;        // Cycles the reset output stays high
	localparam int unsigned HOLD_W        = 4;        // Width of the hold counter
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RST_HOLD_CYC - 1);
	localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;

	// ==========================================================
	// Control states, Gray coded along off -> run -> fire
	// ==========================================================
	typedef enum logic [1:0] {
		WWRT_OFF  = 2'h0,
		WWRT_RUN  = 2'h1,
		WWRT_FIRE = 2'h3
	} wwrt_state_t;

endpackage

`default_nettype wire

// ===== design/wwrt_top.sv
// Warm reset watchdog timer: control, timeout selection and reset output
`timescale 1ns/1ps
`default_nettype none

module wwrt_top #(
	parameter int unsigned CW          = wwrt_pkg::CNT_W_DEF,
	parameter int unsigned TMO_DEF_CYC = wwrt_pkg::TMO_DEF_CYC
) (
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	input  wire logic          warm_rst_in,
	input  wire logic          ctrl_wr,
	input  wire logic          ctrl_enable,
	input  wire logic          tmo_wr,
	input  wire logic [CW-1:0] tmo_value,
	output var  logic          enabled,
	output var  logic [CW-1:0] tmo_sel,
	output var  logic          warm_rst_out,
	output var  logic          wd_rst_out
);
	import wwrt_pkg::*;

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	// Widths past 32 are refused before the bound check shifts a 64-bit one
	generate
		if (CW < 2 || CW > 32) begin : g_bad_width
			$error("Counter width must be 2 to 32");
		end
		if (TMO_DEF_CYC < 1 || (CW < 32 && TMO_DEF_CYC >= (64'h1 << CW))) begin : g_bad_tmo
			$error("Default timeout does not fit the counter");
		end
	endgenerate

	localparam logic [CW-1:0] TMO_DEF = CW'(TMO_DEF_CYC);

	// ==========================================================
	// State and next values
	// ==========================================================
	wwrt_state_t       state;
	wwrt_state_t       next_state;
	logic [HOLD_W-1:0] hold;
	logic [HOLD_W-1:0] next_hold;
	logic [CW-1:0]     next_tmo_sel;
	logic              next_enabled;
	logic              next_warm_rst_out;
	logic              next_wd_rst_out;
	logic              sw_enable;
	logic              sw_disable;

	wwrt_cnt_if #(.CW(CW)) cnt_bus ();

	wwrt_counter #(.CW(CW)) u_counter (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.bus      (cnt_bus)
	);

	// Write strobe split by its data bit
	assign sw_enable  = ctrl_wr && ctrl_enable;
	assign sw_disable = ctrl_wr && !ctrl_enable;

	// Run and limit come from registered state only, never from the decision
	// logic below, so the counter's hit flag cannot loop back through it.
	// An outside warm reset stops the step in its own cycle.
	assign cnt_bus.run   = (state == WWRT_RUN) && !warm_rst_in;
	assign cnt_bus.limit = tmo_sel;

	// ==========================================================
	// Control decisions
	// ==========================================================
	// Expiry outranks every software request in the same cycle, so a late
	// disable or timeout write cannot rescue a period that already ran out.
	always_comb begin
		next_state        = state;
		next_hold         = hold;
		next_tmo_sel      = tmo_sel;
		next_warm_rst_out = 1'b0;
		cnt_bus.clear     = 1'b0;
		if (tmo_wr) begin
			next_tmo_sel = tmo_value;
		end
		if (warm_rst_in) begin
			next_tmo_sel  = TMO_DEF;
			cnt_bus.clear = 1'b1;
		end
		case (state)
			WWRT_OFF: begin
				cnt_bus.clear = 1'b1;
				if (sw_enable) begin
					next_state = WWRT_RUN;
				end
			end
			WWRT_RUN: begin
				// Hit is already gated off by an outside warm reset this cycle
				if (cnt_bus.hit) begin
					next_state        = WWRT_FIRE;
					next_hold         = HOLD_LOAD;
					next_warm_rst_out = 1'b1;
					next_tmo_sel      = TMO_DEF;
					cnt_bus.clear     = 1'b1;
				end else if (sw_disable) begin
					next_state    = WWRT_OFF;
					cnt_bus.clear = 1'b1;
				end
			end
			WWRT_FIRE: begin
				// Disable writes are ignored until the reset output has ended
				cnt_bus.clear = 1'b1;
				if (hold == HOLD_ZERO) begin
					next_state = WWRT_RUN;
				end else begin
					next_hold = hold - HOLD_W'(1);
				end
			end
			default: begin
				next_state    = WWRT_OFF;
				cnt_bus.clear = 1'b1;
			end
		endcase
		next_enabled    = (next_state != WWRT_OFF);
		next_wd_rst_out = (next_state == WWRT_FIRE);
	end

	// ==========================================================
	// Registers; power-on reset freezes everything disabled
	// ==========================================================
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state        <= WWRT_OFF;
			hold         <= HOLD_ZERO;
			tmo_sel      <= TMO_DEF;
			enabled      <= 1'b0;
			warm_rst_out <= 1'b0;
			wd_rst_out   <= 1'b0;
		end else begin
			state        <= next_state;
			hold         <= next_hold;
			tmo_sel      <= next_tmo_sel;
			enabled      <= next_enabled;
			warm_rst_out <= next_warm_rst_out;
			wd_rst_out   <= next_wd_rst_out;
		end
	end

	// ==========================================================
	// Checks and covers
	// ==========================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// These two override the default disable, so the reset cycles themselves are checked
	property p_por_freeze;
		@(posedge core_clk) disable iff (1'b0)
			sys_rst |=> !enabled && !wd_rst_out && cnt_bus.count == '0;
	endproperty
	a_por_freeze: assert property (p_por_freeze)
		else $error("Power-on reset did not freeze the watchdog");

	property p_por_default;
		@(posedge core_clk) disable iff (1'b0)
			sys_rst |=> tmo_sel == TMO_DEF;
	endproperty
	a_por_default_tmo: assert property (p_por_default)
		else $error("Timeout not default after power-on reset");

	a_stays_disabled: assert property (
		!enabled && !sw_enable |=> !enabled && cnt_bus.count == '0)
		else $error("Watchdog left disabled state without enable");

	a_enable_write: assert property (
		!enabled && sw_enable |=> enabled ##1 cnt_bus.count == CW'(1))
		else $error("Enable write did not start counting");

	a_disable_write: assert property (
		state == WWRT_RUN && sw_disable && !cnt_bus.hit |=> !enabled)
		else $error("Disable write did not stop the watchdog");

	a_tmo_write_taken: assert property (
		tmo_wr && !warm_rst_in && !cnt_bus.hit |=> tmo_sel == $past(tmo_value))
		else $error("Timeout write was not taken");

	a_expiry_fires: assert property (
		cnt_bus.hit |=> warm_rst_out && wd_rst_out ##1 !warm_rst_out)
		else $error("Expiry did not issue warm reset");

	a_warm_one_cycle: assert property (warm_rst_out |=> !warm_rst_out)
		else $error("Warm reset request longer than one cycle");

	a_reset_pulse_len: assert property (
		$rose(wd_rst_out) |-> wd_rst_out[*8] ##1 !wd_rst_out)
		else $error("Reset output length wrong");

	a_restart_after: assert property (
		$fell(wd_rst_out) |-> enabled && cnt_bus.count == '0 ##1 cnt_bus.count == CW'(1))
		else $error("Watchdog did not restart after its reset");

	a_warm_default: assert property (
		warm_rst_out || $past(warm_rst_in) |-> tmo_sel == TMO_DEF)
		else $error("Warm reset did not restore default timeout");

	a_ext_warm_restart: assert property (
		warm_rst_in && state == WWRT_RUN && !sw_disable
			|=> enabled && tmo_sel == TMO_DEF && cnt_bus.count == '0)
		else $error("Outside warm reset did not restart the count");

	a_expiry_at_count: assert property (
		state == WWRT_RUN && cnt_bus.count == tmo_sel && !warm_rst_in |=> wd_rst_out)
		else $error("No expiry when count reached timeout");

	c_enable: cover property (!enabled ##1 enabled);
	c_expiry: cover property ($rose(wd_rst_out));
	c_reprogram: cover property (state == WWRT_RUN && tmo_wr);
	c_ext_warm: cover property (state == WWRT_RUN && warm_rst_in);
	c_restart: cover property ($fell(wd_rst_out) ##1 enabled);
endmodule

`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the warm reset watchdog timer
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end

module tb;
	import wwrt_pkg::*;
	// ==========================================================
	// Design and stimulus signals
	// ==========================================================
	localparam int D = 20;	// Short default timeout keeps the run brief
	typedef struct {int at; int tol;} wwrt_tb_note_t;
	logic          core_clk, sys_rst, warm_rst_in, ctrl_wr, ctrl_enable, tmo_wr;
	logic [31:0]   tmo_value, tmo_sel;
	logic          enabled, warm_rst_out, wd_rst_out;
	int            bad_count, tests_run, cyc, hold_len, t2;
	wwrt_tb_note_t notes[$];
	wwrt_tb_note_t n;

	wwrt_top #(.CW(32), .TMO_DEF_CYC(D)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.warm_rst_in(warm_rst_in), .ctrl_wr(ctrl_wr), .ctrl_enable(ctrl_enable),
		.tmo_wr(tmo_wr), .tmo_value(tmo_value), .enabled(enabled), .tmo_sel(tmo_sel),
		.warm_rst_out(warm_rst_out), .wd_rst_out(wd_rst_out));

	// Clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ==========================================================
	// Monitor: counts edges, checks pulses against the notes
	// ==========================================================
	always @(posedge core_clk) cyc <= cyc + 1;
	// Outputs are looked at on the falling edge, where they are settled
	always @(negedge core_clk) begin
		if (wd_rst_out === 1'b1) hold_len = hold_len + 1;
		else if (hold_len != 0) begin
			`CHK("reset_out_len", 8, hold_len)
			hold_len = 0;
		end
		if (warm_rst_out === 1'b1) begin
			if (notes.size() == 0) `CHK("unexpected_fire", 0, 1)
			else begin
				n = notes.pop_front();
				`CHK("fire_cycle", 1, (cyc >= n.at && cyc <= n.at + n.tol))
			end
		end
	end

	// ==========================================================
	// Driver tasks, all changes on the falling edge
	// ==========================================================
	task automatic tick(int k);
		repeat (k) @(negedge core_clk);
	endtask

	// Strobe is taken at the next rising edge: hit after T+1, pulse after T+2
	task automatic expect_fire(int t);
		notes.push_back('{cyc + t + 2, 0});
	endtask

	task automatic ctrl(logic en);
		ctrl_wr = 1'b1;
		ctrl_enable = en;
		tick(1);
		ctrl_wr = 1'b0;
	endtask

	task automatic set_tmo(logic [31:0] v);
		tmo_wr = 1'b1;
		tmo_value = v;
		tick(1);
		tmo_wr = 1'b0;
	endtask

	// Bounded wait for every noted pulse to show up
	task automatic wait_fires();
		for (int i = 0; i < 400 && notes.size() != 0; i++) tick(1);
		if (notes.size() != 0) begin
			bad_count++;
			$display("MISMATCH fire_wait exp=0 got=%0d", notes.size());
			close_out();
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{warm_rst_in, ctrl_wr, ctrl_enable, tmo_wr} = 4'h0;
		tmo_value = 32'h0;
		sys_rst = 1'b1;
		cyc = 0;
		hold_len = 0;
		void'($urandom(59603));
		tick(3);
		sys_rst = 1'b0;
		// Idle after power-on: frozen, default timeout
		tick(40);
		`CHK("idle_enabled", 1'b0, enabled)
		`CHK("default_tmo", D, tmo_sel)
		$display("test idle done");
		// Enable, first expiry, then re-arm on its own
		t2 = cyc + D + 2;
		expect_fire(D);
		ctrl(1'b1);
		`CHK("enabled", 1'b1, enabled)
		wait_fires();
		`CHK("tmo_after_fire", D, tmo_sel)
		`CHK("still_enabled", 1'b1, enabled)
		// Next pulse counted from the first one, not from when the wait ended
		notes.push_back('{t2 + D + 1 + RST_HOLD_CYC, 0});
		wait_fires();
		tick(9);
		ctrl(1'b0);
		`CHK("disabled", 1'b0, enabled)
		tick(40);
		$display("test expiry done");
		// Reprogram while counting, random values above the current count
		for (int k = 0; k < 2; k++) begin
			t2 = 30 + $urandom % 20;
			expect_fire(t2);
			ctrl(1'b1);
			tick(2);
			set_tmo(t2);
			`CHK("tmo_sel_new", t2, tmo_sel)
			wait_fires();
			`CHK("tmo_back_default", D, tmo_sel)
			tick(9);
			ctrl(1'b0);
			tick(1);
		end
		$display("test reprogram done");
		// Outside warm reset discards a programmed value and restarts the count
		ctrl(1'b1);
		tick(3);
		set_tmo(32'h32);
		tick(2);
		expect_fire(D);
		warm_rst_in = 1'b1;
		tick(1);
		warm_rst_in = 1'b0;
		`CHK("tmo_warm", D, tmo_sel)
		wait_fires();
		tick(9);
		$display("test warm reset done");
		// Power-on reset in mid-run freezes the watchdog
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		`CHK("por_enabled", 1'b0, enabled)
		tick(60);
		`CHK("por_tmo", D, tmo_sel)
		$display("test power-on reset done");
		close_out();
	end
endmodule

`default_nettype wire
